//--- rtl/cxc_map.vh
// Purpose: constants for the transceiver control block
// Assumes: 100 MHz aclk
// Notes:   offsets are byte addresses on the register bus
`ifndef CXC_MAP_VH
`define CXC_MAP_VH

// ==========================================
// timing
`define CXC_CLK_HZ          100000000
`define CXC_TIMEOUT_NS      1250000
// least time: round up to whole cycles
`define CXC_TIMEOUT_CYC     ((`CXC_TIMEOUT_NS * (`CXC_CLK_HZ / 1000000) + 999) / 1000)

// ==========================================
// register offsets
`define CXC_OFF_CTRL        8'h00
`define CXC_OFF_STATUS      8'h04
`define CXC_OFF_IRQ_STAT    8'h08
`define CXC_OFF_IRQ_MASK    8'h0C

// ==========================================
// ctrl fields
`define CXC_CTRL_LOOP_BIT   0
`define CXC_CTRL_RESET      1'h0

// ==========================================
// status fields
`define CXC_ST_MODE_LSB     0
`define CXC_ST_TIMEOUT_BIT  3
`define CXC_ST_THERM_BIT    4
`define CXC_ST_GATE_BIT     5
`define CXC_ST_DRIVE_BIT    6
`define CXC_ST_RX_BIT       7

// ==========================================
// event bits (irq status and mask)
`define CXC_EV_TIMEOUT      0
`define CXC_EV_THERM        1
`define CXC_EV_BROWNOUT     2
`define CXC_EV_WAKE         3
`define CXC_EV_W            4
`define CXC_MASK_RESET      4'h0

// ==========================================
// mode codes (one-hot)
`define CXC_MODE_HS         3'h1
`define CXC_MODE_SLOPE      3'h2
`define CXC_MODE_STBY       3'h4

`endif

//--- rtl/cxc_sync.v
// Purpose: two-flop synchroniser for a bundle of level flags
// Assumes: flags change slowly compared with aclk
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps

module cxc_sync #(
  parameter W = 4
) (
  // clock and reset
  input  wire         aclk,
  input  wire         aresetn,
  input  wire         ce,
  // flags
  input  wire [W-1:0] d,
  input  wire [W-1:0] rst_val,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta;

  always @(posedge aclk) begin
    if (!aresetn) begin
      // per-flag reset level, so a flag may come up already asserted
      meta <= rst_val;
      q    <= rst_val;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

//--- rtl/cxc_top.v
// Purpose: digital control of a high-speed CAN bus transceiver
// Assumes: one clock, synchronous reset from power-good logic
// Notes:   bus levels are modelled as dominant flags, not voltages
`timescale 1ns/10ps
`include "cxc_map.vh"

module cxc_top #(
  parameter TIMEOUT_CYC = `CXC_TIMEOUT_CYC
) (
  // clock, reset, enable
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  // controller side
  input  wire        txd_in,
  input  wire        txd_connected,
  output reg         rxd_out,
  // mode select, decoded from the analog pin
  input  wire        slope_mode_select_hi,
  input  wire        slope_mode_select_mid,
  // analog flags
  input  wire        over_temp,
  input  wire        power_on_threshold,
  input  wire        brownout_threshold,
  // bus side
  input  wire        bus_dominant_in,
  output wire        bus_drive_dominant,
  output wire        bus_drive_oe,
  output reg         slope_fast,
  // axi4-lite write address / data / response
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // interrupt
  output wire        irq
);

  // ==========================================
  // mode state machine
  localparam ST_HS    = `CXC_MODE_HS;
  localparam ST_SLOPE = `CXC_MODE_SLOPE;
  localparam ST_STBY  = `CXC_MODE_STBY;

  function is_word;
    input [7:0] a;
    input [7:0] off;
    begin
      is_word = (a[7:2] == off[7:2]);
    end
  endfunction

  // ==========================================
  // synchronised flags
  wire [4:0] flags_q;
  wire       mode_hi;
  wire       mode_mid;
  wire       therm;
  wire       por_hi;
  wire       bo_lo;
  reg  [2:0] mode;
  reg  [2:0] next_mode;
  reg        gate_open;
  reg        wait_txd_high;
  reg        por_seen;
  reg        timed_out;
  reg  [17:0] to_cnt;
  reg        txd_prev;
  reg        loop_ctrl;
  reg  [3:0] irq_stat;
  reg  [3:0] irq_mask;
  reg        stby_prev;
  reg        bo_prev;
  reg        therm_prev;
  reg        to_prev;
  wire       txd;
  wire       drive_en;
  wire       bus_dom;

  cxc_sync #(
    .W (5)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       ({brownout_threshold, power_on_threshold, over_temp,
               slope_mode_select_mid, slope_mode_select_hi}),
    .rst_val (5'h00),
    .q       (flags_q)
  );

  assign mode_hi  = flags_q[0];
  assign mode_mid = flags_q[1];
  assign therm    = flags_q[2];
  assign por_hi   = flags_q[3];
  assign bo_lo    = flags_q[4];

  assign txd = txd_connected ? txd_in : 1'b1;

  // ==========================================
  // mode decode
  // three-way select
  always @* begin
    case (1'b1)
      mode_hi:  next_mode = ST_STBY;
      mode_mid: next_mode = ST_SLOPE;
      default:  next_mode = ST_HS;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      mode       <= ST_HS;
      slope_fast <= 1'b1;
    end else if (ce) begin
      mode       <= next_mode;
      slope_fast <= (next_mode == ST_HS);
    end
  end

  // ==========================================
  // power gating
  always @(posedge aclk) begin
    if (!aresetn) begin
      gate_open     <= 1'b0;
      wait_txd_high <= 1'b0;
      por_seen      <= 1'b0;
    end else if (ce) begin
      if (bo_lo) begin
        gate_open <= 1'b0;
        por_seen  <= 1'b0;
      end else if (por_hi && !por_seen) begin
        por_seen      <= 1'b1;
        wait_txd_high <= !txd;
        gate_open     <= txd;
      end else if (por_seen && wait_txd_high && txd) begin
        wait_txd_high <= 1'b0;
        gate_open     <= 1'b1;
      end
    end
  end

  // ==========================================
  // dominant timeout
  always @(posedge aclk) begin
    if (!aresetn) begin
      to_cnt    <= 18'h00000;
      timed_out <= 1'b0;
      txd_prev  <= 1'b1;
    end else if (ce) begin
      txd_prev <= txd;
      if (txd && !txd_prev) begin
        to_cnt    <= 18'h00000;
        timed_out <= 1'b0;
      end else if (txd) begin
        to_cnt <= 18'h00000;
      end else if (!timed_out) begin
        if (to_cnt >= TIMEOUT_CYC[17:0] - 18'h00001)
          timed_out <= 1'b1;
        else
          to_cnt <= to_cnt + 18'h00001;
      end
    end
  end

  // ==========================================
  // drivers and receiver
  // and of all enables
  assign drive_en = gate_open && !therm && (mode != ST_STBY) && !timed_out && !txd;

  assign bus_drive_dominant = drive_en;
  assign bus_drive_oe       = drive_en;

  assign bus_dom = bus_dominant_in | drive_en;

  always @(posedge aclk) begin
    if (!aresetn)
      rxd_out <= 1'b1;
    else if (ce)
      rxd_out <= loop_ctrl ? txd : !bus_dom;
  end

  // ==========================================
  // register bus
  reg        aw_held;
  reg        w_held;
  reg [7:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  wire       do_write;
  wire [3:0] ev;
  wire [31:0] status_word;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  // events: wake is bus activity seen in standby
  assign ev[`CXC_EV_TIMEOUT]  = timed_out && !to_prev;
  assign ev[`CXC_EV_THERM]    = therm && !therm_prev;
  assign ev[`CXC_EV_BROWNOUT] = bo_lo && !bo_prev;
  assign ev[`CXC_EV_WAKE]     = stby_prev && bus_dom;
  assign irq = |(irq_stat & irq_mask);

  assign status_word = {24'h000000, rxd_out, drive_en, gate_open, therm,
                        timed_out, mode};

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= 2'h0;
      s_axi_rdata  <= 32'h00000000;
      loop_ctrl    <= `CXC_CTRL_RESET;
      irq_stat     <= 4'h0;
      irq_mask     <= `CXC_MASK_RESET;
      stby_prev    <= 1'b0;
      bo_prev      <= 1'b0;
      therm_prev   <= 1'b0;
      to_prev      <= 1'b0;
    end else if (ce) begin
      stby_prev  <= (mode == ST_STBY);
      bo_prev    <= bo_lo;
      therm_prev <= therm;
      to_prev    <= timed_out;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      // set wins over write-one-to-clear
      irq_stat <= irq_stat | ev;
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        if (is_word(aw_addr, `CXC_OFF_CTRL)) begin
          if (w_strb[0])
            loop_ctrl <= w_data[`CXC_CTRL_LOOP_BIT];
        end else if (is_word(aw_addr, `CXC_OFF_IRQ_STAT)) begin
          if (w_strb[0])
            irq_stat <= (irq_stat & ~w_data[3:0]) | ev;
        end else if (is_word(aw_addr, `CXC_OFF_IRQ_MASK)) begin
          if (w_strb[0])
            irq_mask <= w_data[3:0];
        end else if (!is_word(aw_addr, `CXC_OFF_STATUS)) begin
          s_axi_bresp <= 2'h2;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        if (is_word(s_axi_araddr, `CXC_OFF_CTRL))
          s_axi_rdata <= {31'h00000000, loop_ctrl};
        else if (is_word(s_axi_araddr, `CXC_OFF_STATUS))
          s_axi_rdata <= status_word;
        else if (is_word(s_axi_araddr, `CXC_OFF_IRQ_STAT))
          s_axi_rdata <= {28'h0000000, irq_stat};
        else if (is_word(s_axi_araddr, `CXC_OFF_IRQ_MASK))
          s_axi_rdata <= {28'h0000000, irq_mask};
        else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

//--- sim/cxc_props.sv
// Purpose: port checks for the transceiver control block
// Assumes: bus held recessive by others while loopback is on
// Notes:   flags cross two sync flops, so checks allow three cycles
`timescale 1ns/10ps

module cxc_props #(
  parameter TIMEOUT_CYC = 50
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // controller side
  input wire txd_in,
  input wire txd_connected,
  input wire rxd_out,
  // mode and analog flags
  input wire slope_mode_select_hi,
  input wire slope_mode_select_mid,
  input wire over_temp,
  input wire power_on_threshold,
  input wire brownout_threshold,
  // bus side
  input wire bus_dominant_in,
  input wire bus_drive_dominant,
  input wire bus_drive_oe,
  input wire slope_fast
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  // ==========
  // helpers
  // an open pin reads recessive, so it never counts as low
  wire       tx_low = !txd_in && txd_connected;
  wire       drv    = bus_drive_dominant;
  reg [31:0] low_cnt;
  reg        por_seen;
  always @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt  <= 32'h0;
      por_seen <= 1'h0;
    end else if (ce) begin
      low_cnt  <= tx_low ? low_cnt + 32'h1 : 32'h0;
      por_seen <= por_seen | power_on_threshold;
    end
  end
  sequence held3(s);
    s [*3];
  endsequence

  // ==========
  // assertions
  drive_pair_a: assert property (drv == bus_drive_oe)
    else $error("drive and enable differ");
  tx_recess_a: assert property (!tx_low |-> !drv)
    else $error("drive while transmit high");
  rx_dom_a: assert property ((drv || bus_dominant_in) |=> !rxd_out)
    else $error("receive high on dominant bus");
  standby_off_a: assert property (held3(slope_mode_select_hi) |=> !drv)
    else $error("drive in standby");
  thermal_off_a: assert property (held3(over_temp) |=> !drv)
    else $error("drive while hot");
  brownout_off_a: assert property (held3(brownout_threshold) |=> !drv)
    else $error("drive in brown-out");
  fast_mode_a: assert property (held3(!slope_mode_select_hi && !slope_mode_select_mid)
    |=> slope_fast)
    else $error("fast mode not set");
  timeout_off_a: assert property ((low_cnt >= TIMEOUT_CYC) |-> !drv)
    else $error("drive after timeout");
  por_gate_a: assert property (!por_seen |-> !drv)
    else $error("drive before power-on");
endmodule

//--- sim/cxc_ctl_model.sv
// Purpose: protocol controller stand-in on the transmit pin
// Assumes: shares aclk with the block
// Notes:   bit time is given per call, so fast and slow senders fit
`timescale 1ns/10ps

module cxc_ctl_model (
  // clock
  input wire aclk,
  // transmit pin, idles recessive
  output reg txd
);
  initial txd = 1'h1;
  // bounded bit time
  // callers keep bit_cyc short enough that a run of dominant bits stays legal
  task send(input [7:0] pat, input [7:0] bit_cyc);
    integer k;
    for (k = 7; k >= 0; k--) begin
      txd <= pat[k];
      repeat (bit_cyc) @(posedge aclk);
    end
    txd <= 1'h1;
  endtask
  task level(input b);
    txd <= b;
  endtask
endmodule

//--- sim/can_transceiver_control_tb.sv
// Purpose: self-checking bench for the transceiver control block
// Assumes: timeout cut to 50 cycles to keep the run short
// Notes:   loopback is set only in its own test, with the bus left recessive
`timescale 1ns/10ps
`include "cxc_map.vh"

module can_transceiver_control_tb;
  localparam TO = 50;
  // ==========
  // ports
  reg         aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, txd_connected = 1'h1;
  reg         slope_mode_select_hi = 1'h0, slope_mode_select_mid = 1'h0, over_temp = 1'h0;
  reg         power_on_threshold = 1'h0, brownout_threshold = 1'h0, bus_dominant_in = 1'h0;
  reg  [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'hF;
  reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  reg         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  wire        txd_in, rxd_out, bus_drive_dominant, bus_drive_oe, slope_fast, irq;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer     errors = 0, check_count = 0, i;
  reg  [7:0]  r;
  // hi mid hot txd_low bus | drive rxd fast
  reg  [7:0]  rows [0:7] = '{8'h03, 8'h15, 8'h09, 8'h54, 8'h92, 8'h88, 8'h33, 8'h29};

  cxc_ctl_model u_ctl (.aclk, .txd(txd_in));
  cxc_top #(.TIMEOUT_CYC(TO)) dut (
    .aclk, .aresetn, .ce, .txd_in, .txd_connected, .rxd_out, .slope_mode_select_hi,
    .slope_mode_select_mid, .over_temp, .power_on_threshold, .brownout_threshold,
    .bus_dominant_in, .bus_drive_dominant, .bus_drive_oe, .slope_fast, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);

  initial forever #5 aclk = ~aclk;

  // ==========
  // tasks
  task step(input integer n);
    repeat (n) @(posedge aclk);
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg done;
    done = 1'h0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, er);
        done = 1'h1;
      end
    end
    // one idle edge, so a following call never re-raises bready in this step
    @(posedge aclk);
  endtask
  task rd(input [7:0] a, input [31:0] e, input [1:0] er);
    reg done;
    done = 1'h0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, er);
        done = 1'h1;
      end
    end
    @(posedge aclk);
  endtask
  // a low transmit pin as power returns must keep the bus free until it rises
  task gate_check;
    u_ctl.level(1'h0);
    step(5);
    chk(bus_drive_dominant, 1'h0);
    power_on_threshold <= 1'h1;
    brownout_threshold <= 1'h0;
    step(5);
    chk(bus_drive_dominant, 1'h0);
    u_ctl.level(1'h1);
    step(3);
    u_ctl.level(1'h0);
    step(2);
    chk(bus_drive_dominant, 1'h1);
    u_ctl.level(1'h1);
    step(1);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========
  // sequence
  initial begin
    step(12);
    aresetn <= 1'h1;
    gate_check;
    $display("power-up done");
    for (i = 0; i < 8; i++) begin
      r = rows[i];
      slope_mode_select_hi  <= r[7];
      slope_mode_select_mid <= r[6];
      over_temp             <= r[5];
      u_ctl.level(!r[4]);
      bus_dominant_in <= r[3];
      step(5);
      chk(bus_drive_dominant, r[2]);
      chk(rxd_out, r[1]);
      chk(slope_fast, r[0]);
    end
    $display("table done");
    over_temp <= 1'h0;
    bus_dominant_in <= 1'h0;
    step(4);
    rd(`CXC_OFF_STATUS, 32'hA1, 2'h0);
    rd(`CXC_OFF_IRQ_STAT, 32'hA, 2'h0);
    chk(irq, 1'h0);
    wr(`CXC_OFF_IRQ_STAT, 32'hF, 2'h0);
    wr(`CXC_OFF_IRQ_MASK, 32'h1, 2'h0);
    wr(8'h20, 32'h1, 2'h2);
    rd(8'h20, 32'h0, 2'h2);
    u_ctl.send(8'h00, 8'h05);
    rd(`CXC_OFF_IRQ_STAT, 32'h0, 2'h0);
    u_ctl.level(1'h0);
    step(TO + 6);
    chk(bus_drive_dominant, 1'h0);
    chk(irq, 1'h1);
    u_ctl.level(1'h1);
    step(2);
    u_ctl.level(1'h0);
    step(2);
    chk(bus_drive_dominant, 1'h1);
    u_ctl.level(1'h1);
    wr(`CXC_OFF_IRQ_STAT, 32'h1, 2'h0);
    step(1);
    chk(irq, 1'h0);
    $display("timeout done");
    power_on_threshold <= 1'h0;
    brownout_threshold <= 1'h1;
    gate_check;
    rd(`CXC_OFF_IRQ_STAT, 32'h4, 2'h0);
    $display("brown-out done");
    // loopback shows txd on rxd even while standby keeps the bus free
    wr(`CXC_OFF_CTRL, 32'h1, 2'h0);
    slope_mode_select_hi <= 1'h1;
    step(4);
    u_ctl.level(1'h0);
    step(3);
    chk(rxd_out, 1'h0);
    chk(bus_drive_dominant, 1'h0);
    u_ctl.level(1'h1);
    // lane 0 off: the control bit must survive the write
    s_axi_wstrb <= 4'h0;
    wr(`CXC_OFF_CTRL, 32'h0, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(`CXC_OFF_CTRL, 32'h1, 2'h0);
    wr(`CXC_OFF_CTRL, 32'h0, 2'h0);
    slope_mode_select_hi <= 1'h0;
    step(4);
    $display("loopback done");
    // ce low freezes the timer too, so a long low txd must not time out
    ce <= 1'h0;
    u_ctl.level(1'h0);
    step(TO + 10);
    chk(rxd_out, 1'h1);
    u_ctl.level(1'h1);
    step(1);
    ce <= 1'h1;
    step(2);
    rd(`CXC_OFF_STATUS, 32'hA1, 2'h0);
    rd(`CXC_OFF_IRQ_STAT, 32'h4, 2'h0);
    $display("clock enable done");
    txd_connected <= 1'h0;
    u_ctl.level(1'h0);
    step(3);
    chk(bus_drive_dominant, 1'h0);
    $display("open pin done");
    report_and_stop;
  end

  // watchdog: the whole run needs well under 1000 cycles
  initial begin
    step(3000);
    errors++;
    report_and_stop;
  end
endmodule

bind cxc_top cxc_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_props (
  .aclk, .aresetn, .ce, .txd_in, .txd_connected, .rxd_out, .slope_mode_select_hi,
  .slope_mode_select_mid, .over_temp, .power_on_threshold, .brownout_threshold,
  .bus_dominant_in, .bus_drive_dominant, .bus_drive_oe, .slope_fast);
